//--- src/ssc_defines.svh
// constants for the synchronous command input stage
// Contract
// [R1] address pins, two low bits included, registered on rising edge select location
// [R2] byte write selects active low, sampled on edge, combined with write strobe
// [R3] each select gates one lane and its parity; high select leaves lane unwritten
// [R4] write strobe sampled only in cycles where the clock qualifier is low
// [R5] controller drives write strobe low to begin a write sequence
// [R6] advance high with qualifier low steps the burst counter
// [R7] advance low loads the address pins as a new access start
// [R8] after deselect controller drives advance low to load a fresh address
// [R9] all synchronous inputs captured on rising edge of the single clock
// [R10] qualifier high edges cause no capture and no state change
// [R11] selected only when first and third selects low and second high
// [R12] first select is active low, sampled on edge, used jointly
// [R13] third select is active low, sampled on edge, used jointly
// [R14] qualifier high freezes state and does not deselect
// [R15] data outputs forced off during the write data phase
// [R16] lanes are nine bits; wide organisation four lanes, narrow two
// [R17] burst counter changes only two low address bits, wrapping in four
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
`define SSC_ADDR_W 21
`define SSC_LANES 4
`define SSC_LANE_W 9
`define SSC_BURST_W 2
`define SSC_DEPTH_W 6
`endif

//--- src/ssc_pkg.sv
// types for the synchronous command input stage
`include "ssc_defines.svh"
package ssc_pkg;
  typedef logic [`SSC_ADDR_W-1:0] ssc_addr_t;
  typedef logic [`SSC_LANES-1:0] ssc_lanes_t;
  typedef logic [`SSC_LANES*`SSC_LANE_W-1:0] ssc_data_t;
  typedef enum logic [2:0] {
    SSC_IDLE = 3'b001,
    SSC_READ = 3'b010,
    SSC_WRITE = 3'b100
  } ssc_op_e;
endpackage

//--- src/ssc_mem.sv
// small lane-masked memory with registered read data
`timescale 1ns/10ps
`include "ssc_defines.svh"
module ssc_mem (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [`SSC_LANES-1:0] lane_en,
  input wire logic [`SSC_DEPTH_W-1:0] addr,
  input wire logic [`SSC_LANES*`SSC_LANE_W-1:0] wdata,
  input wire logic rd_en,
  output logic [`SSC_LANES*`SSC_LANE_W-1:0] rdata
);
  logic [`SSC_LANES*`SSC_LANE_W-1:0] mem [0:(1<<`SSC_DEPTH_W)-1];
  always_ff @(posedge clk) begin
    for (int i = 0; i < `SSC_LANES; i++) begin
      // [R3] one select per lane
      if (wr_en && lane_en[i]) begin
        mem[addr][i*`SSC_LANE_W +: `SSC_LANE_W] <= wdata[i*`SSC_LANE_W +: `SSC_LANE_W];
      end
    end
    if (rd_en) begin
      rdata <= mem[addr];
    end
  end
endmodule

//--- src/ssc_top.sv
// command and address input stage of a pipelined burst memory
`timescale 1ns/10ps
`include "ssc_defines.svh"
module ssc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire ssc_pkg::ssc_addr_t addr_in,
  input wire logic clock_qualify_n,
  input wire logic write_strobe_n,
  input wire logic advance_or_load,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic select_third_n,
  input wire logic lane_a_write_sel_n,
  input wire logic lane_b_write_sel_n,
  input wire logic lane_c_write_sel_n,
  input wire logic lane_d_write_sel_n,
  input wire ssc_pkg::ssc_data_t wdata_in,
  output ssc_pkg::ssc_addr_t cur_addr,
  output logic selected,
  output logic write_cycle,
  output ssc_pkg::ssc_lanes_t lane_write,
  output logic data_oe_n,
  output ssc_pkg::ssc_data_t rdata_out
);
  import ssc_pkg::*;

  typedef struct packed {
    logic [1:0] rst_sync;
    ssc_addr_t addr;
    ssc_op_e op;
    ssc_lanes_t lanes;
    logic wr_phase;
    logic oe_n;
    logic active;
    ssc_lanes_t lane_wr;
  } ssc_state_s;

  ssc_state_s st_ff;
  ssc_state_s nxt_st;
  logic rst_sync_n;
  ssc_data_t mem_q;

  assign rst_sync_n = st_ff.rst_sync[1];

  // [R12] [R13] joint select decode
  function automatic logic is_selected(input logic s1_n, input logic s2, input logic s3_n);
    return !s1_n && s2 && !s3_n;
  endfunction

  // [R2] active low lane selects
  function automatic ssc_lanes_t lane_sel(input logic a_n, input logic b_n, input logic c_n,
      input logic d_n);
    return ~{d_n, c_n, b_n, a_n};
  endfunction

  // pins are sampled directly on the edge: a synchronous memory input register,
  // so the controller is assumed to meet setup on clk
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
    // [R10] qualifier gates all capture
    if (!clock_qualify_n) begin
      // [R11] select decode
      if (is_selected(select_first_n, select_second, select_third_n)) begin
        // [R7] load new address
        if (!advance_or_load) begin
          // [R1] address, low bits included
          nxt_st.addr = addr_in;
          // [R4] strobe sampled with qualifier low
          nxt_st.op = write_strobe_n ? SSC_READ : SSC_WRITE;
          // [R2] active low lane selects
          nxt_st.lanes = lane_sel(lane_a_write_sel_n, lane_b_write_sel_n,
                                  lane_c_write_sel_n, lane_d_write_sel_n);
        end else if (st_ff.op != SSC_IDLE) begin
          // [R6] advance steps counter
          // [R17] step low bits only
          nxt_st.addr[`SSC_BURST_W-1:0] = st_ff.addr[`SSC_BURST_W-1:0] + 2'h1;
          nxt_st.lanes = lane_sel(lane_a_write_sel_n, lane_b_write_sel_n,
                                  lane_c_write_sel_n, lane_d_write_sel_n);
        end
      end else begin
        nxt_st.op = SSC_IDLE;
        nxt_st.lanes = 4'h0;
      end
      // [R15] outputs off in write data phase
      nxt_st.wr_phase = (nxt_st.op == SSC_WRITE);
      nxt_st.oe_n = (nxt_st.op != SSC_READ);
      // registered copies so every output leaves a flop
      nxt_st.active = (nxt_st.op != SSC_IDLE);
      nxt_st.lane_wr = nxt_st.wr_phase ? nxt_st.lanes : 4'h0;
    end
  end

  // [R9] rising edge capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{rst_sync: 2'h0, addr: '0, op: SSC_IDLE, lanes: 4'h0,
                 wr_phase: 1'b0, oe_n: 1'b1, active: 1'b0, lane_wr: 4'h0};
    end else if (!rst_sync_n) begin
      st_ff <= '{rst_sync: nxt_st.rst_sync, addr: '0, op: SSC_IDLE, lanes: 4'h0,
                 wr_phase: 1'b0, oe_n: 1'b1, active: 1'b0, lane_wr: 4'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // [R16] four lanes of nine
  ssc_mem u_mem (
    .clk(clk),
    .wr_en(st_ff.wr_phase && !clock_qualify_n),
    .lane_en(st_ff.lanes),
    .addr(st_ff.addr[`SSC_DEPTH_W-1:0]),
    .wdata(wdata_in),
    .rd_en(st_ff.op == SSC_READ && !clock_qualify_n),
    .rdata(mem_q)
  );

  assign cur_addr = st_ff.addr;
  assign selected = st_ff.active;
  assign write_cycle = st_ff.wr_phase;
  assign lane_write = st_ff.lane_wr;
  assign data_oe_n = st_ff.oe_n;
  assign rdata_out = mem_q;

  // [R14] qualifier high freezes state
  property p_freeze;
    @(posedge clk) disable iff (!rst_sync_n)
      clock_qualify_n |=> $stable(st_ff.addr) && $stable(st_ff.op);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while qualifier high"); // [R14]

  property p_deselect;
    @(posedge clk) disable iff (!rst_sync_n)
      (!clock_qualify_n && !is_selected(select_first_n, select_second, select_third_n))
      |=> !selected;
  endproperty
  a_deselect: assert property (p_deselect) else $error("not deselected"); // [R11]

  property p_load;
    @(posedge clk) disable iff (!rst_sync_n)
      (!clock_qualify_n && !advance_or_load &&
       is_selected(select_first_n, select_second, select_third_n))
      |=> cur_addr == $past(addr_in);
  endproperty
  a_load: assert property (p_load) else $error("address not loaded"); // [R7]

  property p_burst;
    @(posedge clk) disable iff (!rst_sync_n)
      (!clock_qualify_n && advance_or_load && selected &&
       is_selected(select_first_n, select_second, select_third_n))
      |=> cur_addr[`SSC_ADDR_W-1:`SSC_BURST_W] == $past(cur_addr[`SSC_ADDR_W-1:`SSC_BURST_W])
          && cur_addr[1:0] == $past(cur_addr[1:0]) + 2'h1;
  endproperty
  a_burst: assert property (p_burst) else $error("burst step wrong"); // [R6]

  property p_write;
    @(posedge clk) disable iff (!rst_sync_n)
      (!clock_qualify_n && !advance_or_load && !write_strobe_n &&
       is_selected(select_first_n, select_second, select_third_n))
      |=> write_cycle && data_oe_n;
  endproperty
  a_write: assert property (p_write) else $error("write not started"); // [R4]

  property p_lane;
    @(posedge clk) disable iff (!rst_sync_n)
      (!clock_qualify_n && !advance_or_load && !write_strobe_n && lane_a_write_sel_n &&
       is_selected(select_first_n, select_second, select_third_n))
      |=> !lane_write[0];
  endproperty
  a_lane: assert property (p_lane) else $error("unselected lane written"); // [R3]

  property p_read_no_write;
    @(posedge clk) disable iff (!rst_sync_n)
      (!clock_qualify_n && !advance_or_load && write_strobe_n) |=> !write_cycle;
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("write without strobe"); // [R2]

  property p_oe;
    @(posedge clk) disable iff (!rst_sync_n)
      write_cycle |-> data_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("driving during write"); // [R15]

  // one qualified edge with the device selected
  sequence s_sel_cmd;
    !clock_qualify_n && is_selected(select_first_n, select_second, select_third_n);
  endsequence

  // a load that also carries a write
  sequence s_load_write;
    s_sel_cmd ##0 (!advance_or_load && !write_strobe_n);
  endsequence

  // [R3] lane map follows selects
  property p_lane_map;
    @(posedge clk) disable iff (!rst_sync_n)
      s_load_write |=> lane_write == ~$past({lane_d_write_sel_n, lane_c_write_sel_n,
                                             lane_b_write_sel_n, lane_a_write_sel_n});
  endproperty
  a_lane_map: assert property (p_lane_map) else $error("lane map wrong"); // [R3]

  // [R4] strobe masked by qualifier
  property p_wr_masked;
    @(posedge clk) disable iff (!rst_sync_n)
      (clock_qualify_n && !write_strobe_n && !write_cycle) |=> !write_cycle;
  endproperty
  a_wr_masked: assert property (p_wr_masked) else $error("masked strobe taken"); // [R4]

  // [R6] advance keeps the access
  property p_burst_keep;
    @(posedge clk) disable iff (!rst_sync_n)
      (s_sel_cmd ##0 (advance_or_load && selected))
      |=> selected && write_cycle == $past(write_cycle);
  endproperty
  a_burst_keep: assert property (p_burst_keep) else $error("advance dropped access"); // [R6]

  // [R6] advance ignored while idle
  property p_adv_idle;
    @(posedge clk) disable iff (!rst_sync_n)
      (!clock_qualify_n && advance_or_load && !selected) |=> !selected;
  endproperty
  a_adv_idle: assert property (p_adv_idle) else $error("advance restarted access"); // [R6]

  // [R15] idle device keeps outputs off
  property p_idle_off;
    @(posedge clk) disable iff (!rst_sync_n)
      !selected |-> data_oe_n && !write_cycle && lane_write == 4'h0;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle device active"); // [R15]

  // [R11] selected read turns outputs on
  property p_read_on;
    @(posedge clk) disable iff (!rst_sync_n)
      (s_sel_cmd ##0 (!advance_or_load && write_strobe_n)) |=> selected && !data_oe_n;
  endproperty
  a_read_on: assert property (p_read_on) else $error("read not started"); // [R11]
endmodule

//--- tb/ssc_ctrl_model.sv
// controller model driving the command inputs
`timescale 1ns/10ps
module ssc_ctrl_model (
  input wire logic clk,
  output ssc_pkg::ssc_addr_t addr_in,
  output logic clock_qualify_n,
  output logic write_strobe_n,
  output logic advance_or_load,
  output logic [2:0] sel,
  output logic [3:0] bw_n,
  output ssc_pkg::ssc_data_t wdata_in
);
  import ssc_pkg::*;
  ssc_data_t nxt;
  task automatic step(input logic q, input logic [2:0] s, input logic w, input logic v,
      input ssc_addr_t a, input logic [3:0] b, input ssc_data_t d);
    @(posedge clk);
    #1;
    {clock_qualify_n, sel, write_strobe_n, advance_or_load} = {q, s, w, v};
    addr_in = a;
    bw_n = b;
    // data lags its command by one cycle
    wdata_in = nxt;
    nxt = d;
  endtask
  initial begin
    {clock_qualify_n, sel, write_strobe_n, advance_or_load} = 6'b0_110_10;
    addr_in = '0;
    bw_n = 4'hf;
    wdata_in = '0;
    nxt = '1;
  end
endmodule

//--- tb/ssc_top_tb_top.sv
// self-checking bench for the command input stage
`timescale 1ns/10ps
module ssc_top_tb_top;
  import ssc_pkg::*;
  localparam logic [2:0] SEL = 3'b010;
  localparam logic [2:0] DES = 3'b110;
  logic clk, rst_n, q, w, v, so, wc, oe;
  logic [2:0] s;
  logic [3:0] b, lw, pb;
  ssc_addr_t a, ca;
  ssc_data_t d, rd, m, pd;
  int errors, comparisons, cycles, i;
  ssc_ctrl_model ctl (.clk(clk), .addr_in(a), .clock_qualify_n(q), .write_strobe_n(w),
    .advance_or_load(v), .sel(s), .bw_n(b), .wdata_in(d));
  ssc_top dut (.clk(clk), .rst_n(rst_n), .addr_in(a), .clock_qualify_n(q),
    .write_strobe_n(w), .advance_or_load(v), .select_first_n(s[2]),
    .select_second(s[1]), .select_third_n(s[0]), .lane_a_write_sel_n(b[0]),
    .lane_b_write_sel_n(b[1]), .lane_c_write_sel_n(b[2]), .lane_d_write_sel_n(b[3]),
    .wdata_in(d), .cur_addr(ca), .selected(so), .write_cycle(wc),
    .lane_write(lw), .data_oe_n(oe), .rdata_out(rd));
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // cut a hang short well past the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      results;
    end
  end
  initial begin
    rst_n = 0;
    repeat (8) @(posedge clk);
    #1;
    chk({lw, so, wc, oe, ca}, {7'b0000_001, 21'h0});
    rst_n = 1;
    repeat (2) @(posedge clk);
    pb = 4'h0;
    pd = 36'h0;
    m = '1;
    ctl.step(0, SEL, 0, 0, 21'h10, pb, pd);
    for (i = 0; i < 6; i++) begin
      if (i < 5) begin
        ctl.step(0, SEL, 0, 0, 21'h10, ~(4'h1 << i), {4{9'h0a5 + i[8:0]}});
      end else begin
        ctl.step(0, SEL, 1, 0, 21'h10, 4'hf, 36'h0);
      end
      chk({so, wc, oe, lw, ca}, {3'b111, ~pb, 21'h10});
      for (int j = 0; j < 4; j++) begin
        if (!pb[j]) m[j*9 +: 9] = pd[j*9 +: 9];
      end
      pb = ~(4'h1 << i);
      pd = {4{9'h0a5 + i[8:0]}};
    end
    ctl.step(0, DES, 1, 0, 21'h0, 4'hf, 36'h0);
    chk({so, wc, oe, ca}, {3'b100, 21'h10});
    ctl.step(0, SEL, 1, 0, 21'h1abcf, 4'hf, 36'h0);
    chk(rd, m);
    ctl.step(0, SEL, 1, 1, 21'h0, 4'hf, 36'h0);
    chk(ca, 21'h1abcf);
    ctl.step(1, DES, 0, 0, 21'h0, 4'h0, 36'h0);
    chk({so, oe, ca}, {2'b10, 21'h1abcc});
    ctl.step(0, DES, 1, 0, 21'h0, 4'hf, 36'h0);
    chk({so, wc, oe, ca}, {3'b100, 21'h1abcc});
    ctl.step(0, SEL, 1, 1, 21'h3, 4'hf, 36'h0);
    chk(so, 1'b0);
    ctl.step(0, DES, 1, 0, 21'h0, 4'hf, 36'h0);
    chk(so, 1'b0);
    for (i = 0; i < 8; i++) begin
      ctl.step(0, i[2:0], 1, 0, 21'h5, 4'hf, 36'h0);
      ctl.step(0, DES, 1, 0, 21'h0, 4'hf, 36'h0);
      chk(so, i == 2);
    end
    ctl.step(0, SEL, 1, 0, 21'h7, 4'hf, 36'h0);
    ctl.step(0, DES, 1, 0, 21'h0, 4'hf, 36'h0);
    chk({so, oe, ca}, {2'b10, 21'h7});
    rst_n = 0;
    #1;
    chk({lw, so, wc, oe, ca}, {7'b0000_001, 21'h0});
    @(posedge clk);
    #1;
    rst_n = 1;
    repeat (2) @(posedge clk);
    ctl.step(0, SEL, 1, 0, 21'h9, 4'hf, 36'h0);
    ctl.step(0, DES, 1, 0, 21'h0, 4'hf, 36'h0);
    chk({so, oe, ca}, {2'b10, 21'h9});
    results;
  end
endmodule
